//--- design/icu_pkg.sv
// package of constants for the interrupt control unit with idle wake
package icu_pkg;
  localparam int          ICU_DATA_W    = 32;
  localparam int          ICU_CRN_W     = 4;
  localparam int          ICU_NUM_INT   = 4;
  localparam logic [3:0]  ICU_CPNUM     = 4'hD;
  localparam logic [3:0]  ICU_CRN_CTRL  = 4'h0;
  localparam logic [3:0]  ICU_CRN_SRC   = 4'h4;
  localparam logic [3:0]  ICU_CRN_ROUTE = 4'h8;
  localparam int          ICU_FAST_BIT  = 31;
  localparam int          ICU_NORM_BIT  = 30;
  localparam int          ICU_CTRL_FAST = 0;
  localparam int          ICU_CTRL_NORM = 1;
  localparam int          ICU_CTRL_INT0 = 2;
  localparam int          ICU_SRC_INT0  = 0;
  localparam logic [31:0] ICU_CTRL_RST  = 32'h0000_0000;
  localparam logic [31:0] ICU_ROUTE_RST = 32'h0000_0000;
  localparam int          ICU_SYNC_STG  = 2;
  localparam int          ICU_WAKE_CLKS = 10;
  localparam logic [1:0]  ICU_PWR_RUN   = 2'h0;
  localparam logic [1:0]  ICU_PWR_IDLE  = 2'h1;
  localparam logic [1:0]  ICU_PWR_SLEEP = 2'h3;
  typedef enum logic [3:0] {
    ICU_ST_RUN   = 4'h1,
    ICU_ST_DRAIN = 4'h2,
    ICU_ST_IDLE  = 4'h4,
    ICU_ST_SLEEP = 4'h8
  } icu_pwr_state_t;
endpackage

//--- design/icu_power.sv
// idle and sleep sequencer driving the power state output
`timescale 1ns/1ps
module icu_power
  import icu_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       enter_idle,
  input  wire logic       enter_sleep,
  input  wire logic       core_quiet,
  input  wire logic       mem_clk_ok,
  input  wire logic       ext_any,
  output logic            idle_busy,
  output logic      [1:0] pwr_state
);
  localparam int CW = $clog2(ICU_WAKE_CLKS + 1);
  icu_pwr_state_t  st_q;
  icu_pwr_state_t  st_d;
  logic            sleep_q;
  logic            sleep_d;
  logic [CW-1:0]   cnt_q;
  logic [CW-1:0]   cnt_d;
  logic [1:0]      pwr_q;
  logic [1:0]      pwr_d;
  always_comb begin
    st_d    = st_q;
    sleep_d = sleep_q;
    cnt_d   = cnt_q;
    pwr_d   = pwr_q;
    case (st_q)
      ICU_ST_RUN: begin
        pwr_d = ICU_PWR_RUN;
        if (enter_idle || enter_sleep) begin
          sleep_d = enter_sleep;
          st_d    = ICU_ST_DRAIN;
        end
      end
      ICU_ST_DRAIN: begin
        if (core_quiet) begin
          pwr_d = sleep_q ? ICU_PWR_SLEEP : ICU_PWR_IDLE;
          cnt_d = '0;
          st_d  = sleep_q ? ICU_ST_SLEEP : ICU_ST_IDLE;
        end
      end
      ICU_ST_IDLE: begin
        // wake ignores masks and disable bits
        if (ext_any && mem_clk_ok) begin
          if (cnt_q == CW'(ICU_WAKE_CLKS - ICU_SYNC_STG - 1)) begin
            pwr_d = ICU_PWR_RUN;
            st_d  = ICU_ST_RUN;
          end else begin
            cnt_d = cnt_q + CW'(1);
          end
        end
      end
      ICU_ST_SLEEP: begin
        // only reset leaves sleep
        pwr_d = ICU_PWR_SLEEP;
      end
      default: begin
        st_d  = ICU_ST_RUN;
        pwr_d = ICU_PWR_RUN;
      end
    endcase
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q    <= ICU_ST_RUN;
      sleep_q <= 1'b0;
      cnt_q   <= '0;
      pwr_q   <= ICU_PWR_RUN;
    end else begin
      st_q    <= st_d;
      sleep_q <= sleep_d;
      cnt_q   <= cnt_d;
      pwr_q   <= pwr_d;
    end
  end
  assign idle_busy = (st_q != ICU_ST_RUN);
  assign pwr_state = pwr_q;
endmodule // icu_power

//--- design/icu_sync.sv
// two-stage synchroniser for the active-low external interrupt pins
`timescale 1ns/1ps
module icu_sync
  import icu_pkg::*;
#(
  parameter int WIDTH = 2
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] pin_n,
  output logic      [WIDTH-1:0] level
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s1_d;
  logic [WIDTH-1:0] s2_d;
  always_comb begin
    s1_d = ~pin_n;
    s2_d = s1_q;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
    end
  end
  assign level = s2_q;
endmodule // icu_sync

//--- design/icu_top.sv
// interrupt control unit top: coprocessor registers, masking, steering, idle wake
`timescale 1ns/1ps
module icu_top
  import icu_pkg::*;
#(
  parameter int NUM_INT = ICU_NUM_INT
) (
  input  wire logic                  CLK,
  input  wire logic                  SYS_RST,
  input  wire logic                  FAST_IRQ_PIN_N,
  input  wire logic                  NORMAL_IRQ_PIN_N,
  input  wire logic [NUM_INT-1:0]    INTERNAL_IRQ,
  input  wire logic                  CP_VALID,
  input  wire logic                  CP_WRITE,
  input  wire logic [3:0]            CP_NUM,
  input  wire logic [2:0]            CP_OPCODE1,
  input  wire logic [2:0]            CP_OPCODE2,
  input  wire logic [3:0]            CP_CRM,
  input  wire logic [3:0]            CP_CRN,
  input  wire logic [31:0]           CP_WDATA,
  output logic                       CP_ACCEPT,
  output logic      [31:0]           CP_RDATA,
  input  wire logic                  CORE_FIQ_DISABLE,
  input  wire logic                  CORE_IRQ_DISABLE,
  input  wire logic                  ENTER_IDLE,
  input  wire logic                  ENTER_SLEEP,
  input  wire logic                  CORE_QUIET,
  input  wire logic                  MEM_CLK_ACTIVE,
  output logic                       FAST_CORE_REQUEST,
  output logic                       NORMAL_CORE_REQUEST,
  output logic                       CORE_IDLE,
  output logic      [1:0]            POWER_STATE_OUT
);
  logic [1:0]          ext_lvl;
  logic                ext_fast;
  logic                ext_norm;
  logic [31:0]         ctrl_q;
  logic [31:0]         ctrl_d;
  logic [31:0]         route_q;
  logic [31:0]         route_d;
  logic [31:0]         rdata_q;
  logic [31:0]         rdata_d;
  logic [31:0]         src_word;
  logic [NUM_INT-1:0]  int_en;
  logic [NUM_INT-1:0]  to_fast;
  logic [NUM_INT-1:0]  to_norm;
  logic                hit;
  logic                fast_raw;
  logic                norm_raw;
  logic                fast_q;
  logic                norm_q;

  icu_sync #(
    .WIDTH (2)
  ) u_sync (
    .clk   (CLK),
    .rst   (SYS_RST),
    .pin_n ({FAST_IRQ_PIN_N, NORMAL_IRQ_PIN_N}),
    .level (ext_lvl)
  );
  assign ext_fast = ext_lvl[1];
  assign ext_norm = ext_lvl[0];

  // coprocessor decode, non-zero opcode fields are not claimed
  assign hit = CP_VALID && (CP_NUM == ICU_CPNUM) && (CP_OPCODE1 == 3'h0)
               && (CP_OPCODE2 == 3'h0) && (CP_CRM == 4'h0);
  assign CP_ACCEPT = hit;

  // source word: live levels, never latched, mask ignored
  always_comb begin
    src_word = '0;
    src_word[ICU_FAST_BIT] = ext_fast;
    src_word[ICU_NORM_BIT] = ext_norm;
    src_word[ICU_SRC_INT0 +: NUM_INT] = INTERNAL_IRQ;
  end

  always_comb begin
    ctrl_d  = ctrl_q;
    route_d = route_q;
    rdata_d = rdata_q;
    if (hit && CP_WRITE) begin
      case (CP_CRN)
        ICU_CRN_CTRL:  ctrl_d  = CP_WDATA;
        ICU_CRN_ROUTE: route_d = CP_WDATA;
        default: begin
        end
      endcase
    end else if (hit) begin
      case (CP_CRN)
        ICU_CRN_CTRL:  rdata_d = ctrl_q;
        ICU_CRN_SRC:   rdata_d = src_word;
        ICU_CRN_ROUTE: rdata_d = route_q;
        default:       rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      ctrl_q  <= ICU_CTRL_RST;
      route_q <= ICU_ROUTE_RST;
      rdata_q <= '0;
    end else begin
      ctrl_q  <= ctrl_d;
      route_q <= route_d;
      rdata_q <= rdata_d;
    end
  end
  assign CP_RDATA = rdata_q;

  // per-source enable and steering; route bit set sends to fast
  for (genvar i = 0; i < NUM_INT; i++) begin : g_int
    assign int_en[i]  = INTERNAL_IRQ[i] && ctrl_q[ICU_CTRL_INT0 + i];
    assign to_fast[i] = int_en[i] && route_q[i];
    assign to_norm[i] = int_en[i] && !route_q[i];
  end

  // combinational from the register so a write masks the very next cycle
  always_comb begin
    fast_raw = (ext_fast && ctrl_q[ICU_CTRL_FAST]) || (|to_fast);
    norm_raw = (ext_norm && ctrl_q[ICU_CTRL_NORM]) || (|to_norm);
    fast_q   = fast_raw && !CORE_FIQ_DISABLE;
    norm_q   = norm_raw && !CORE_IRQ_DISABLE;
  end
  assign FAST_CORE_REQUEST   = fast_q;
  assign NORMAL_CORE_REQUEST = norm_q;

  icu_power u_power (
    .clk         (CLK),
    .rst         (SYS_RST),
    .enter_idle  (ENTER_IDLE),
    .enter_sleep (ENTER_SLEEP),
    .core_quiet  (CORE_QUIET),
    .mem_clk_ok  (MEM_CLK_ACTIVE),
    .ext_any     (ext_fast || ext_norm),
    .idle_busy   (CORE_IDLE),
    .pwr_state   (POWER_STATE_OUT)
  );
endmodule // icu_top

//--- tb/icu_irq_src.sv
// external interrupter model driving the active-low pins
`timescale 1ns/1ps
module icu_irq_src (
  input  wire logic fire_fast,
  input  wire logic fire_norm,
  output logic      fast_n,
  output logic      norm_n
);
  // no test-port clock is modelled: it stays stopped at 0
  // pin held low while firing, pulled up once released
  assign fast_n = !fire_fast;
  assign norm_n = !fire_norm;
endmodule // icu_irq_src

//--- tb/icu_top_props.sv
// assertion checker for the interrupt control unit top
`timescale 1ns/1ps
module icu_top_props
  import icu_pkg::*;
#(
  parameter int NUM_INT = ICU_NUM_INT
) (
  input wire logic               CLK,
  input wire logic               SYS_RST,
  input wire logic               FAST_IRQ_PIN_N,
  input wire logic               NORMAL_IRQ_PIN_N,
  input wire logic [NUM_INT-1:0] INTERNAL_IRQ,
  input wire logic               CP_VALID,
  input wire logic               CP_WRITE,
  input wire logic [3:0]         CP_NUM,
  input wire logic [2:0]         CP_OPCODE1,
  input wire logic [2:0]         CP_OPCODE2,
  input wire logic [3:0]         CP_CRM,
  input wire logic               CP_ACCEPT,
  input wire logic [31:0]        CP_RDATA,
  input wire logic               CORE_FIQ_DISABLE,
  input wire logic               CORE_IRQ_DISABLE,
  input wire logic               CORE_QUIET,
  input wire logic               FAST_CORE_REQUEST,
  input wire logic               NORMAL_CORE_REQUEST,
  input wire logic               CORE_IDLE,
  input wire logic [1:0]         POWER_STATE_OUT
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  AST_CLASS_OFF: assert property (!(FAST_CORE_REQUEST && CORE_FIQ_DISABLE) && !(NORMAL_CORE_REQUEST && CORE_IRQ_DISABLE))
    else $error("request while class disabled");
  AST_DECODE: assert property (CP_ACCEPT |-> CP_VALID && CP_NUM == ICU_CPNUM && CP_OPCODE1 == 3'h0 && CP_OPCODE2 == 3'h0 && CP_CRM == 4'h0)
    else $error("access claimed on bad decode");
  AST_SYNC: assert property ($fell(FAST_IRQ_PIN_N) && !FAST_CORE_REQUEST |=> !FAST_CORE_REQUEST || INTERNAL_IRQ != 0)
    else $error("pin reached request without sync");
  AST_RDATA: assert property (!$past(CP_VALID && CP_ACCEPT && !CP_WRITE) |-> $stable(CP_RDATA))
    else $error("read data moved without read");
  AST_PWR_CODE: assert property (POWER_STATE_OUT != 2'h2)
    else $error("reserved power code");
  AST_IDLE_IN: assert property ($past(POWER_STATE_OUT) == ICU_PWR_RUN && POWER_STATE_OUT == ICU_PWR_IDLE |-> $past(CORE_QUIET))
    else $error("idle entered before quiet");
  AST_WAKE: assert property ($past(POWER_STATE_OUT) == ICU_PWR_IDLE && POWER_STATE_OUT == ICU_PWR_RUN
    |-> ($past(!FAST_IRQ_PIN_N || !NORMAL_IRQ_PIN_N, 2) || $past(!FAST_IRQ_PIN_N || !NORMAL_IRQ_PIN_N, 3))
    && $past(!FAST_IRQ_PIN_N || !NORMAL_IRQ_PIN_N, 10))
    else $error("wake without pin");
  AST_CORE_IDLE: assert property (POWER_STATE_OUT != ICU_PWR_RUN |-> CORE_IDLE)
    else $error("core not idle in low power");
  AST_SLEEP: assert property (POWER_STATE_OUT == ICU_PWR_SLEEP |=> POWER_STATE_OUT == ICU_PWR_SLEEP)
    else $error("sleep left without reset");
  cover property (POWER_STATE_OUT == ICU_PWR_IDLE);
  cover property (POWER_STATE_OUT == ICU_PWR_SLEEP);
  cover property (FAST_CORE_REQUEST && NORMAL_CORE_REQUEST);
endmodule // icu_top_props
bind icu_top icu_top_props #(.NUM_INT(NUM_INT)) u_props (.CLK, .SYS_RST, .FAST_IRQ_PIN_N, .NORMAL_IRQ_PIN_N,
  .INTERNAL_IRQ, .CP_VALID, .CP_WRITE, .CP_NUM, .CP_OPCODE1, .CP_OPCODE2, .CP_CRM, .CP_ACCEPT, .CP_RDATA,
  .CORE_FIQ_DISABLE, .CORE_IRQ_DISABLE, .CORE_QUIET, .FAST_CORE_REQUEST, .NORMAL_CORE_REQUEST, .CORE_IDLE,
  .POWER_STATE_OUT);

//--- tb/tb_icu_top.sv
// self-checking testbench for the interrupt control unit
`timescale 1ns/1ps
module tb_icu_top;
  import icu_pkg::*;
  logic clk = 0, rst = 1, vld = 0, wr = 0, fd = 0, nd = 0, idl = 0, slp = 0, qt = 0, ff = 0, nf = 0, rv = 0;
  logic mck = 1;
  logic fast_n, norm_n, acc, freq, nreq, cidle;
  logic [2:0] op = 0, op2 = 0;
  logic [3:0] crn = 0, irq = 0, rt, cpn = ICU_CPNUM, crm = 0;
  logic [31:0] wd = 0, rd, q[$];
  logic [1:0] pwr;
  int num_errors = 0, check_count = 0, n;
  icu_irq_src SRC (.fire_fast(ff), .fire_norm(nf), .fast_n(fast_n), .norm_n(norm_n));
  icu_top DUT (.CLK(clk), .SYS_RST(rst), .FAST_IRQ_PIN_N(fast_n), .NORMAL_IRQ_PIN_N(norm_n), .INTERNAL_IRQ(irq),
    .CP_VALID(vld), .CP_WRITE(wr), .CP_NUM(cpn), .CP_OPCODE1(op), .CP_OPCODE2(op2), .CP_CRM(crm),
    .CP_CRN(crn), .CP_WDATA(wd), .CP_ACCEPT(acc), .CP_RDATA(rd), .CORE_FIQ_DISABLE(fd), .CORE_IRQ_DISABLE(nd),
    .ENTER_IDLE(idl), .ENTER_SLEEP(slp), .CORE_QUIET(qt), .MEM_CLK_ACTIVE(mck), .FAST_CORE_REQUEST(freq),
    .NORMAL_CORE_REQUEST(nreq), .CORE_IDLE(cidle), .POWER_STATE_OUT(pwr));
  initial forever #12.5 clk = !clk;
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(int k);
    repeat (k) @(negedge clk);
  endtask
  // one access; on a read the data word is the expected value
  task automatic cp(logic w, logic [3:0] r, logic [31:0] d);
    logic ok;
    ok = (cpn == ICU_CPNUM) && (op == 3'h0) && (op2 == 3'h0) && (crm == 4'h0);
    @(negedge clk) vld = 1;
    wr = w;
    crn = r;
    wd = d;
    if (!w && ok) q.push_back(d);
    #1 chk({31'h0, acc}, {31'h0, ok});
    @(negedge clk) vld = 0;
  endtask
  task automatic req(logic f, logic m);
    chk({30'h0, freq, nreq}, {30'h0, f, m});
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk) rv <= vld && acc && !wr;
  always @(negedge clk) if (rv) chk(rd, q.pop_front());
  initial begin
    #100000;
    num_errors++;
    give_verdict;
  end
  initial begin
    void'($urandom(84));
    cyc(2);
    rst = 0;
    cp(0, ICU_CRN_CTRL, 0);
    cp(0, ICU_CRN_ROUTE, 0);
    cp(0, 4'hC, 0);
    rt = 4'($urandom);
    cp(1, ICU_CRN_ROUTE, {28'h0, rt});
    cp(1, ICU_CRN_CTRL, 32'h3F);
    cp(0, ICU_CRN_ROUTE, {28'h0, rt});
    for (int i = 0; i < 4; i++) begin
      irq = 4'h1 << i;
      cyc(1);
      req(rt[i], !rt[i]);
      cp(0, ICU_CRN_SRC, {28'h0, irq});
    end
    irq = 4'hF;
    cp(1, ICU_CRN_CTRL, 0);
    req(0, 0);
    cp(0, ICU_CRN_SRC, 32'hF);
    cp(1, ICU_CRN_CTRL, 32'h3F);
    fd = 1;
    nd = 1;
    cyc(1);
    req(0, 0);
    {fd, nd, irq, ff, nf} = 8'h03;
    $display("internal routing done");
    cyc(1);
    req(0, 0);
    cyc(1);
    req(1, 1);
    cp(0, ICU_CRN_SRC, 32'hC000_0000);
    {ff, nf} = 2'h0;
    req(1, 1);
    cyc(3);
    req(0, 0);
    op = 3'h1;
    cp(1, ICU_CRN_CTRL, 0);
    {op, op2} = 6'h01;
    cp(1, ICU_CRN_CTRL, 0);
    {op2, crm} = 7'h01;
    cp(1, ICU_CRN_CTRL, 0);
    {crm, cpn} = 8'h0E;
    cp(1, ICU_CRN_CTRL, 0);
    cp(0, ICU_CRN_CTRL, 0);
    cpn = ICU_CPNUM;
    cp(0, ICU_CRN_CTRL, 32'h3F);
    cp(1, ICU_CRN_CTRL, 0);
    $display("pins done");
    idl = 1;
    cyc(1);
    idl = 0;
    qt = 1;
    cyc(3);
    chk({29'h0, cidle, pwr}, {29'h0, 1'b1, ICU_PWR_IDLE});
    {mck, nf} = 2'h1;
    cyc(12);
    chk({29'h0, cidle, pwr}, {29'h0, 1'b1, ICU_PWR_IDLE});
    nf = 0;
    cyc(3);
    {mck, nf} = 2'h3;
    n = 0;
    while (pwr !== ICU_PWR_RUN && n < 20) begin
      cyc(1);
      n++;
    end
    chk(32'(n), 32'(ICU_WAKE_CLKS));
    nf = 0;
    slp = 1;
    cyc(1);
    slp = 0;
    cyc(3);
    ff = 1;
    cyc(12);
    chk({30'h0, pwr}, {30'h0, ICU_PWR_SLEEP});
    {ff, rst} = 2'h1;
    cyc(2);
    rst = 0;
    chk({30'h0, pwr}, 32'h0);
    $display("power done");
    give_verdict;
  end
endmodule // tb_icu_top
